//--- design/adc_input_channel_sequencer.sv
// Input channel sequencer: pin configuration, selectors, alternation, scanning, power
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module adc_input_channel_sequencer
    import adc_seq_pkg::*;
#(
    parameter int NUM_PINS = 16,
    parameter bit HAS_BANDGAP = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port side of the pins
    input wire logic [NUM_PINS-1:0] pin_direction,
    input wire logic [NUM_PINS-1:0] port_drive_level,
    // Sample timing from the converter
    input wire logic sample_start,
    input wire logic sample_end,
    input wire logic sequence_done,
    input wire logic converter_interrupt,
    // Pin routing, selection, references and power
    output logic [NUM_PINS-1:0] digital_input_enable,
    output logic [NUM_PINS-1:0] mux_to_analog_ground,
    output logic [NUM_PINS-1:0] convert_port_level,
    output mux_sel_t sh_select,
    output ref_sel_t ref_select,
    output logic module_powered
);

    // ========================================================
    // Register bank
    // ========================================================
    // Each register sits in the low half
    // of a bus word; the upper half reads 0.
    // Only byte lanes 0 and 1 carry bits.
    logic [15:0] control_1_q;
    logic [15:0] control_2_q;
    logic [15:0] channel_select_q;
    logic [15:0] analog_pin_config_q;
    // Top two bits: band gap inputs only
    logic [1:0] pin_config_high_q;
    logic [15:0] scan_mask_low_q;
    logic [1:0] scan_mask_high_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;

    // Decodes a known register address
    // Status is known but read-only
    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            ADDR_CONTROL_1, ADDR_CONTROL_2, ADDR_CHANNEL_SELECT, ADDR_PIN_CONFIG_LOW,
            ADDR_PIN_CONFIG_HIGH, ADDR_SCAN_MASK_LOW, ADDR_SCAN_MASK_HIGH,
            ADDR_STATUS: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    // Merges byte lanes of a 16-bit register
    // Lanes without a strobe keep old bits
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        merge16 = old;
        if (st[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (st[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    logic wr_fire;
    logic rd_fire;
    // Writes land where ready is seen high,
    // so a stalled access never writes twice.
    // Reads capture one edge earlier, so the
    // data stands when ready is sampled.
    assign wr_fire = psel && penable && pready_q && pwrite;
    assign rd_fire = psel && penable && !pready_q && !pwrite;

    // One wait state: ready rises in the second access cycle
    // and falls after one cycle, so a setup that follows
    // at once is never taken for a second access phase
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
        end
    end

    // Error flag for unmapped addresses
    // Raised with ready, for one cycle
    // Unmapped writes are dropped below
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= psel && penable && !pready_q && !addr_known(paddr);
        end
    end

    // Writes land at the edge where ready is sampled high
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            control_1_q <= RESET_REG16;
            control_2_q <= RESET_REG16;
            channel_select_q <= RESET_REG16;
            analog_pin_config_q <= RESET_REG16;
            pin_config_high_q <= RESET_REG16[1:0];
            scan_mask_low_q <= RESET_REG16;
            scan_mask_high_q <= RESET_REG16[1:0];
        end else if (wr_fire) begin
            case (paddr)
                ADDR_CONTROL_1: control_1_q <= merge16(control_1_q, pwdata, pstrb);
                ADDR_CONTROL_2: control_2_q <= merge16(control_2_q, pwdata, pstrb);
                ADDR_CHANNEL_SELECT: channel_select_q <= merge16(channel_select_q, pwdata, pstrb);
                ADDR_PIN_CONFIG_LOW: analog_pin_config_q <= merge16(analog_pin_config_q, pwdata,
                                                                    pstrb);
                ADDR_PIN_CONFIG_HIGH: begin
                    if (pstrb[0]) begin
                        pin_config_high_q <= pwdata[1:0];
                    end
                end
                ADDR_SCAN_MASK_LOW: scan_mask_low_q <= merge16(scan_mask_low_q, pwdata, pstrb);
                ADDR_SCAN_MASK_HIGH: begin
                    if (pstrb[0]) begin
                        scan_mask_high_q <= pwdata[1:0];
                    end
                end
                // Unmapped and read-only words change nothing
                default: ;
            endcase
        end
    end

    // ========================================================
    // Derived controls
    // ========================================================
    // Positive field, four bits wide unless
    // the band gap inputs exist
    function automatic logic [4:0] positive_field(input logic [15:0] r, input int lsb);
        positive_field = {1'b0, r[lsb +: 4]};
        if (HAS_BANDGAP) begin
            positive_field = r[lsb +: 5];
        end
    endfunction

    logic module_on;
    logic alt_enable;
    logic scan_enable;
    logic [2:0] reference_config;
    logic [3:0] samples_per_irq;
    logic [4:0] first_positive_channel;
    logic [4:0] second_positive_channel;
    logic first_negative_select;
    logic second_negative_select;
    logic [17:0] scan_mask;

    assign module_on = control_1_q[MODULE_ON_BIT];
    assign alt_enable = control_2_q[ALT_SEL_BIT];
    assign scan_enable = control_2_q[SCAN_EN_BIT];
    assign reference_config = control_2_q[REF_CFG_LSB +: 3];
    // Stored as the count minus one
    assign samples_per_irq = control_2_q[SAMPLES_LSB +: 4];
    assign first_positive_channel = positive_field(channel_select_q, FIRST_POS_LSB);
    assign second_positive_channel = positive_field(channel_select_q, SECOND_POS_LSB);
    assign first_negative_select = channel_select_q[FIRST_NEG_BIT];
    assign second_negative_select = channel_select_q[SECOND_NEG_BIT];
    // Band gap scan bits only exist on band gap variants
    assign scan_mask = {(HAS_BANDGAP ? scan_mask_high_q : 2'b00), scan_mask_low_q};

    // ========================================================
    // Sequencing state
    // ========================================================
    // The converter reports each finished
    // sequence and each interrupt; the state
    // here readies the selection for the
    // next sample before its window opens.
    // Scan setup changes apply at the next
    // sample only.
    logic use_second_q;
    logic [4:0] scan_ptr_q;
    logic [4:0] scan_taken_q;
    logic sampling_q;

    // Lowest marked channel at or above a start position
    // Searched from the top, so the lowest match wins
    function automatic logic [5:0] next_marked(input logic [17:0] mask, input logic [4:0] from);
        next_marked = 6'h3f;
        for (int i = 17; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= from)) begin
                next_marked = {1'b0, 5'(i)};
            end
        end
    endfunction

    logic [5:0] scan_first;
    logic [5:0] scan_next;
    logic [4:0] scan_start;
    assign scan_first = next_marked(scan_mask, 5'h00);
    assign scan_next = next_marked(scan_mask, scan_ptr_q + 5'h01);
    // With nothing marked the pointer rests at channel zero
    assign scan_start = scan_first[5] ? 5'h00 : scan_first[4:0];

    // Alternation toggles once per finished sequence
    // Interrupt and power-off win over a finished one
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            use_second_q <= 1'b0;
        end else if (!module_on || converter_interrupt || !alt_enable) begin
            use_second_q <= 1'b0;
        end else if (sequence_done) begin
            use_second_q <= !use_second_q;
        end
    end

    // Scan pointer steps upward only after a first selector sample
    // Taken samples are counted against the limit
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            scan_ptr_q <= 5'h00;
            scan_taken_q <= 5'h00;
        end else if (!module_on || converter_interrupt) begin
            scan_ptr_q <= scan_start;
            scan_taken_q <= 5'h00;
        end else if (sequence_done && scan_enable && !use_second_q) begin
            scan_taken_q <= scan_taken_q + 5'h01;
            // Past the last marked channel the pointer parks; higher ones wait
            if (!scan_next[5] && (scan_taken_q < {1'b0, samples_per_irq})) begin
                scan_ptr_q <= scan_next[4:0];
            end
        end else if (scan_taken_q == 5'h00 && !scan_first[5]) begin
            scan_ptr_q <= scan_first[4:0];
        end
    end

    // Tracks an open sample window
    // End wins, and power-off closes it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sampling_q <= 1'b0;
        end else if (!module_on || sample_end) begin
            sampling_q <= 1'b0;
        end else if (sample_start) begin
            sampling_q <= 1'b1;
        end
    end

    // ========================================================
    // Selection to the sample-and-hold
    // ========================================================
    mux_sel_t sel_d;
    mux_sel_t sh_select_q;

    // Next selection: the second selector on
    // alternate turns, otherwise the first
    always_comb begin
        sel_d = '0;
        sel_d.valid = module_on;
        if (use_second_q) begin
            sel_d.positive = second_positive_channel;
            sel_d.negative = second_negative_select ? NEG_INPUT_ONE : NEG_LOWER_REF;
        end else begin
            sel_d.positive = scan_enable ? scan_ptr_q : first_positive_channel;
            sel_d.negative = first_negative_select ? NEG_INPUT_ONE : NEG_LOWER_REF;
        end
    end

    // Selection frozen while a sample window is open
    // Settled before a start, held to the end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sh_select_q <= '0;
        end else if (!module_on) begin
            sh_select_q <= '0;
        end else if (!sampling_q && !sample_start) begin
            sh_select_q <= sel_d;
        end
    end

    // ========================================================
    // Pin and power outputs
    // ========================================================
    logic [NUM_PINS-1:0] din_en_q;
    logic [NUM_PINS-1:0] gnd_q;
    logic [NUM_PINS-1:0] conv_port_q;
    logic [NUM_PINS-1:0] conv_port_d;
    ref_sel_t ref_q;
    logic powered_q;

    // Analog pin driven as an output
    // converts the port's own level
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_conv
        assign conv_port_d[p] = !analog_pin_config_q[p] && !pin_direction[p];
    end

    // Per-pin routing from the analog configuration bits
    // A digital pin keeps its buffer on, mux grounded
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            din_en_q <= '0;
            gnd_q <= '0;
            conv_port_q <= '0;
        end else begin
            din_en_q <= analog_pin_config_q[NUM_PINS-1:0];
            gnd_q <= analog_pin_config_q[NUM_PINS-1:0];
            conv_port_q <= conv_port_d;
        end
    end

    // Reference choice and power
    // Field bit 0 upper, bit 1 lower external pin
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ref_q <= '0;
            powered_q <= 1'b0;
        end else begin
            ref_q.upper_external <= reference_config[0];
            ref_q.lower_external <= reference_config[1];
            powered_q <= module_on;
        end
    end

    logic [11:0] status_word;
    // Window open, turn, samples taken, pointer
    assign status_word = {sampling_q, use_second_q, scan_taken_q, scan_ptr_q};

    // Read data mux
    // Captured in the first access cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prdata_q <= '0;
        end else if (rd_fire) begin
            case (paddr)
                ADDR_CONTROL_1: prdata_q <= {16'h0000, control_1_q};
                ADDR_CONTROL_2: prdata_q <= {16'h0000, control_2_q};
                ADDR_CHANNEL_SELECT: prdata_q <= {16'h0000, channel_select_q};
                ADDR_PIN_CONFIG_LOW: prdata_q <= {16'h0000, analog_pin_config_q};
                ADDR_PIN_CONFIG_HIGH: prdata_q <= {30'h00000000, pin_config_high_q};
                ADDR_SCAN_MASK_LOW: prdata_q <= {16'h0000, scan_mask_low_q};
                ADDR_SCAN_MASK_HIGH: prdata_q <= {30'h00000000, scan_mask_high_q};
                ADDR_STATUS: prdata_q <= {20'h00000, status_word};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign digital_input_enable = din_en_q;
    assign mux_to_analog_ground = gnd_q;
    assign convert_port_level = conv_port_q;
    assign sh_select = sh_select_q;
    assign ref_select = ref_q;
    assign module_powered = powered_q;

endmodule

//--- design/adc_seq_pkg.sv
// Package: register map, field layouts and reset values of the input channel sequencer
//
// Behaviour
// - A pin is analog when its configuration bit is zero, digital when one.
// - Device reset clears the pin configuration, so all pins start analog.
// - Analog pins have their digital input buffer turned off.
// - Digital pins connect their multiplexer input to analog ground instead.
// - Analog pin driven as digital output converts the port's own level.
// - Positive channel fields: first selector bits 3..0, second 11..8.
// - Band gap variants widen both positive fields to five bits.
// - Negative bit 7 or 15 set picks input one, else lower reference.
// - Alternate bit clear: sample only the first selector's inputs.
// - Alternate bit set: first, then second selector, repeating.
// - Scan enable ignores first positive field and walks the scan mask.
// - Each scan mask bit includes exactly its own channel.
// - Scan ascends and restarts at the lowest channel after each interrupt.
// - Marked channels beyond the per-interrupt sample count stay unsampled.
// - In scanning, negative input still comes from the first negative bit.
// - Scan applies only to first selector; alternation uses fixed second.
// - Module-on bit powers the module; clear cuts power and resets selection and sequencing; pin routing and references stay.
// - Three-bit reference field in control 2 bits 15..13 picks references.
package adc_seq_pkg;
    // Byte addresses on the register bus
    localparam logic [7:0] ADDR_CONTROL_1 = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_2 = 8'h04;
    localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h08;
    localparam logic [7:0] ADDR_PIN_CONFIG_LOW = 8'h0c;
    localparam logic [7:0] ADDR_PIN_CONFIG_HIGH = 8'h10;
    localparam logic [7:0] ADDR_SCAN_MASK_LOW = 8'h14;
    localparam logic [7:0] ADDR_SCAN_MASK_HIGH = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    // Field positions
    localparam int MODULE_ON_BIT = 15;
    localparam int ALT_SEL_BIT = 0;
    localparam int SCAN_EN_BIT = 10;
    localparam int REF_CFG_LSB = 13;
    localparam int SAMPLES_LSB = 2;
    localparam int FIRST_POS_LSB = 0;
    localparam int FIRST_NEG_BIT = 7;
    localparam int SECOND_POS_LSB = 8;
    localparam int SECOND_NEG_BIT = 15;
    // Reset values
    localparam logic [15:0] RESET_REG16 = 16'h0000;
    localparam logic [1:0] RESET_PIN_DIR = 2'h3;
    // Negative input codes
    localparam logic NEG_LOWER_REF = 1'b0;
    localparam logic NEG_INPUT_ONE = 1'b1;

    // Multiplexer selection handed to the sample-and-hold
    typedef struct packed {
        logic [4:0] positive;
        logic negative;
        logic valid;
    } mux_sel_t;

    // Reference choice
    typedef struct packed {
        logic upper_external;
        logic lower_external;
    } ref_sel_t;
endpackage

//--- verif/adc_seq_monitor.sv
// Checker: port-level properties of the input channel sequencer
`timescale 1ns/100ps
module adc_seq_monitor
    import adc_seq_pkg::*;
#(
    parameter int NUM_PINS = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [NUM_PINS-1:0] pin_direction,
    input wire logic sample_start,
    input wire logic sample_end,
    input wire logic [NUM_PINS-1:0] digital_input_enable,
    input wire logic [NUM_PINS-1:0] mux_to_analog_ground,
    input wire logic [NUM_PINS-1:0] convert_port_level,
    input wire mux_sel_t sh_select,
    input wire ref_sel_t ref_select,
    input wire logic module_powered
);
    // ========================================
    // Helper state
    logic sampling_q;
    logic wr_now;
    assign wr_now = psel & pwrite;
    // Tracks the open sample window
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sampling_q <= 1'b0;
        end else if (sample_start) begin
            sampling_q <= 1'b1;
        end else if (sample_end) begin
            sampling_q <= 1'b0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ========================================
    // Properties
    ground_follows_cfg_a: assert property (mux_to_analog_ground == digital_input_enable)
        else $error("ground tie differs from buffer enable");
    convert_level_a: assert property (!$past(reset) |->
        convert_port_level == (~digital_input_enable & ~$past(pin_direction)))
        else $error("port level conversion wrong");
    cfg_by_write_a: assert property ($changed(digital_input_enable) |->
        $past(wr_now, 2) || $past(wr_now, 3))
        else $error("pin mode changed without write");
    hold_sample_a: assert property (sampling_q && $past(sampling_q) |->
        $stable(sh_select))
        else $error("selection moved during sample");
    access_ready_a: assert property (psel && $rose(penable) |=> pready)
        else $error("ready not in second access cycle");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    power_by_write_a: assert property ($changed(module_powered) |->
        $past(wr_now, 2) || $past(wr_now, 3))
        else $error("power changed without write");
    ref_by_write_a: assert property ($changed(ref_select) |->
        $past(wr_now, 2) || $past(wr_now, 3))
        else $error("reference changed without write");
endmodule
bind adc_input_channel_sequencer adc_seq_monitor #(.NUM_PINS(NUM_PINS)) adc_seq_monitor_inst (
    .clk_sys, .reset, .psel, .penable, .pwrite, .pready, .pin_direction, .sample_start,
    .sample_end, .digital_input_enable, .mux_to_analog_ground, .convert_port_level,
    .sh_select, .ref_select, .module_powered);

//--- verif/sh_amp_model.sv
// Partner: sample-and-hold timing seen from the analog side
`timescale 1ns/100ps
module sh_amp_model
    import adc_seq_pkg::*;
#(
    parameter int SETTLE_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic go,
    input wire logic [3:0] hold_cycles,
    input wire logic module_powered,
    input wire mux_sel_t sh_select,
    output logic sample_start,
    output logic sample_end,
    output logic sequence_done,
    output logic done,
    output mux_sel_t taken
);
    int settle;
    // Counts analog settling after power-on
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            settle <= 0;
        end else if (!module_powered) begin
            settle <= 0;
        end else if (settle < SETTLE_CYCLES) begin
            settle <= settle + 1;
        end
    end
    // One sample: start, hold, capture at end, then conversion done
    initial begin
        {sample_start, sample_end, sequence_done, done} = 4'h0;
        taken = '0;
        forever begin
            @(posedge clk_sys);
            if (go && settle >= SETTLE_CYCLES) begin
                sample_start <= 1'b1;
                @(posedge clk_sys);
                sample_start <= 1'b0;
                repeat (hold_cycles) @(posedge clk_sys);
                sample_end <= 1'b1;
                taken <= sh_select;
                @(posedge clk_sys);
                sample_end <= 1'b0;
                sequence_done <= 1'b1;
                @(posedge clk_sys);
                sequence_done <= 1'b0;
                done <= 1'b1;
                @(posedge clk_sys);
                done <= 1'b0;
            end
        end
    end
endmodule

//--- verif/tb_adc_input_channel_sequencer.sv
// Testbench: register access and input selection sequences
`timescale 1ns/100ps
module tb_adc_input_channel_sequencer;
    import adc_seq_pkg::*;
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, go, done, e;
    logic sample_start, sample_end, sequence_done, converter_interrupt, module_powered;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, hold_cycles;
    logic [15:0] pin_direction, port_drive_level, digital_input_enable;
    logic [15:0] mux_to_analog_ground, convert_port_level;
    mux_sel_t sh_select, taken;
    ref_sel_t ref_select;
    int num_errors = 0;
    int num_checks = 0;
    adc_input_channel_sequencer #(.NUM_PINS(16), .HAS_BANDGAP(1'b1))
        adc_input_channel_sequencer_inst (
        .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .pin_direction, .port_drive_level, .sample_start, .sample_end, .sequence_done,
        .converter_interrupt, .digital_input_enable, .mux_to_analog_ground, .convert_port_level,
        .sh_select, .ref_select, .module_powered);
    sh_amp_model sh_amp_model_inst (.clk_sys, .reset, .go, .hold_cycles, .module_powered,
        .sh_select, .sample_start, .sample_end, .sequence_done, .done, .taken);
    // ========================================
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("Watchdog expired");
        end_sim();
    end
    // ========================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        chk("ready", 32'h1, 32'(n < 20));
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
        chk("write error", 32'h0, 32'(e));
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk("read", exp, rd);
    endtask
    task automatic irq();
        @(posedge clk_sys);
        converter_interrupt <= 1'b1;
        @(posedge clk_sys);
        converter_interrupt <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic smp(input logic [4:0] p, input logic n);
        int k;
        k = 0;
        @(posedge clk_sys);
        go <= 1'b1;
        while (done !== 1'b1 && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        go <= 1'b0;
        chk("positive", 32'(p), 32'(taken.positive));
        chk("negative", 32'(n), 32'(taken.negative));
    endtask
    task automatic end_sim();
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial begin
        {reset, psel, penable, pwrite, go, converter_interrupt} = 6'h20;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        hold_cycles = 4'h1;
        pin_direction = 16'h00ff;
        port_drive_level = 16'h5a5a;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) rdchk(8'(i * 4), 32'h0);
        chk("buffers", 32'h0, 32'(digital_input_enable));
        apb(8'h40, 1'b0, 32'h0);
        chk("unmapped error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, rd);
        wr(ADDR_PIN_CONFIG_LOW, 32'h0000f0f0);
        rdchk(ADDR_PIN_CONFIG_LOW, 32'h0000f0f0);
        chk("buffers", 32'h0000f0f0, 32'(digital_input_enable));
        chk("ground", 32'h0000f0f0, 32'(mux_to_analog_ground));
        chk("convert", 32'h00000f00, 32'(convert_port_level));
        pin_direction <= 16'h0000;
        repeat (3) @(posedge clk_sys);
        chk("convert", 32'h00000f0f, 32'(convert_port_level));
        wr(ADDR_CHANNEL_SELECT, 32'h00000a91);
        wr(ADDR_CONTROL_1, 32'h00008000);
        chk("power", 32'h1, 32'(module_powered));
        irq();
        smp(5'h11, 1'b1);
        smp(5'h11, 1'b1);
        wr(ADDR_CONTROL_2, 32'h00000001);
        irq();
        smp(5'h11, 1'b1);
        hold_cycles <= 4'h6;
        smp(5'h0a, 1'b0);
        smp(5'h11, 1'b1);
        wr(ADDR_SCAN_MASK_LOW, 32'h00000124);
        wr(ADDR_CONTROL_2, 32'h00000408);
        irq();
        smp(5'h02, 1'b1);
        smp(5'h05, 1'b1);
        smp(5'h08, 1'b1);
        irq();
        smp(5'h02, 1'b1);
        wr(ADDR_CONTROL_2, 32'h00000409);
        irq();
        smp(5'h02, 1'b1);
        smp(5'h0a, 1'b0);
        smp(5'h05, 1'b1);
        wr(ADDR_CONTROL_1, 32'h00000000);
        chk("power", 32'h0, 32'(module_powered));
        wr(ADDR_CONTROL_1, 32'h00008000);
        smp(5'h02, 1'b1);
        smp(5'h0a, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CONTROL_2, 32'(i) << 13);
            chk("reference", 32'({i[0], i[1]}), 32'(ref_select));
        end
        end_sim();
    end
endmodule
